/* verilog/pls_pkg.sv */
// Summary of operation
// - Parallel port loads feedback and post-divide values
// - Parallel strobe rising edge captures inputs
// - Parallel strobe low makes latches transparent
// - Parallel path beats serial path
// - Undriven parallel inputs read as one
// - Serial shift register is twelve bits
// - Shift one bit per serial clock rise
// - Serial strobe falling edge captures shift register
// - Serial strobe high makes latches follow register
// - Test-select field picks diagnostic output source
// - Slow-down request divides output by sixteen
// - Slow-down sequenced and sampled by reference clock
// - Slow-down moves in four discrete steps
// - Post-divider ratios one to eight, even duty
// - Post-select codes map to two, four, eight, one
// - Feedback divider uses programmed feedback value
// - Output gate changes with output clock only
// - Reference select picks crystal or external clock
`default_nettype none
package pls_pkg;
  localparam int SR_LEN = 12;
  localparam int FB_W = 7;
  localparam int POST_W = 8;
  localparam int T_LSB = 0;
  localparam int N_LSB = 3;
  localparam int M_LSB = 5;
  localparam logic [2:0] SLOW_STEPS = 3'h4;
  localparam logic [7:0] POST_DIV2 = 8'h02;
  localparam logic [7:0] POST_DIV4 = 8'h04;
  localparam logic [7:0] POST_DIV8 = 8'h08;
  localparam logic [7:0] POST_DIV1 = 8'h01;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CFG = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic CTRL_RST = 1'h1;
  localparam logic [6:0] CFG_M_RST = 7'h7F;
  localparam logic [1:0] CFG_N_RST = 2'h3;
  localparam logic [2:0] CFG_T_RST = 3'h0;
  localparam logic PIN_PLOAD_RST = 1'h1;
  localparam logic PIN_REFSEL_RST = 1'h1;

  typedef struct packed {
    logic [6:0] m;
    logic [1:0] n;
    logic [2:0] t;
  } pls_cfg_s;
endpackage
`default_nettype wire

/* verilog/pls_sync.sv */
`default_nettype none
module pls_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  if (W < 1) begin
    $error("pls_sync width must be positive");
  end

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule
`default_nettype wire

/* verilog/pls_div.sv */
`default_nettype none
module pls_div
  import pls_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic en,
  input wire logic [W-1:0] ratio,
  output logic out_q
);
  if (W < 1 || W > 16) begin
    $error("pls_div width out of range");
  end

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic out_d;

  // Toggle every ratio ticks gives an even duty cycle
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (en) begin
      if ({1'b0, cnt_q} + {{W{1'b0}}, 1'b1} >= {1'b0, ratio}) begin
        cnt_d = '0;
        out_d = ~out_q;
      end else begin
        cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end
endmodule
`default_nettype wire

/* verilog/pls_ctrl.sv */
// Decided for this implementation: the register offsets and the APB interface to the registers.
`default_nettype none
module pls_ctrl
  import pls_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  input wire logic [6:0] par_fb_div_in,
  input wire logic [6:0] par_fb_div_drive,
  input wire logic [1:0] par_post_sel_in,
  input wire logic [1:0] par_post_sel_drive,
  input wire logic par_latch_n,
  input wire logic ser_clock,
  input wire logic ser_data,
  input wire logic ser_latch,
  input wire logic output_enable,
  input wire logic slow_down_request,
  input wire logic ref_source_select,
  input wire logic xtal_ref_in,
  input wire logic external_reference_in,
  input wire logic vco_tick,
  output logic ref_clk_q,
  output logic fb_clk_q,
  output logic fout_q,
  output logic fout_n_q,
  output logic diag_q
);
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [6:0] m_in_s;
  logic [6:0] m_drv_s;
  logic [1:0] n_in_s;
  logic [1:0] n_drv_s;
  logic [6:0] m_s;
  logic [1:0] n_s;
  logic pl_s;
  logic sl_s;
  logic sclk_s;
  logic sd_s;
  logic oe_s;
  logic sdr_s;
  logic rsel_s;
  logic xref_s;
  logic eref_s;

  // Pull-ups applied after the synchronisers
  always_comb begin
    m_s = m_in_s | ~m_drv_s;
    n_s = n_in_s | ~n_drv_s;
  end

  pls_sync #(.W(18), .RST({CFG_M_RST, CFG_N_RST, 9'h000})) u_sync_par (
    .clk(clk),
    .reset(reset),
    .d({par_fb_div_in, par_post_sel_in, par_fb_div_drive, par_post_sel_drive}),
    .q({m_in_s, n_in_s, m_drv_s, n_drv_s})
  );

  pls_sync #(.W(9), .RST({PIN_PLOAD_RST, 7'h00, PIN_REFSEL_RST})) u_sync_ctl (
    .clk(clk),
    .reset(reset),
    .d({par_latch_n, ser_latch, ser_clock, ser_data, output_enable,
        slow_down_request, xtal_ref_in, external_reference_in,
        ref_source_select}),
    .q({pl_s, sl_s, sclk_s, sd_s, oe_s, sdr_s, xref_s, eref_s, rsel_s})
  );

  ////////////////////////////////////////////////////////////////////
  // State
  pls_cfg_s cfg_q, cfg_d, ser_cfg;
  logic [SR_LEN-1:0] sr_q, sr_d;
  logic pl_prev_q, pl_prev_d;
  logic sl_prev_q, sl_prev_d;
  logic sclk_prev_q, sclk_prev_d;
  logic ref_lvl_q, ref_lvl_d;
  logic slow_req_q, slow_req_d;
  logic [2:0] step_q, step_d;
  logic gate_q, gate_d;
  logic ctrl_en_q, ctrl_en_d;
  logic [7:0] ratio_q, ratio_d;
  logic ref_clk_d, fout_d, fout_n_d, diag_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic post_out, fb_out;
  logic ref_tick, pl_rise, sl_fall, sclk_rise, apb_wr;
  logic [7:0] base;

  pls_div #(.W(FB_W)) u_fb_div (
    .clk(clk),
    .reset(reset),
    .en(vco_tick),
    .ratio(cfg_q.m),
    .out_q(fb_out)
  );

  pls_div #(.W(POST_W)) u_post_div (
    .clk(clk),
    .reset(reset),
    .en(vco_tick),
    .ratio(ratio_q),
    .out_q(post_out)
  );

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    pl_prev_d = pl_s;
    sl_prev_d = sl_s;
    sclk_prev_d = sclk_s;
    pl_rise = pl_s & ~pl_prev_q;
    sl_fall = sl_prev_q & ~sl_s;
    sclk_rise = sclk_s & ~sclk_prev_q;
    // Reference pick and edge detect
    ref_lvl_d = rsel_s ? xref_s : eref_s;
    ref_clk_d = ref_lvl_q;
    ref_tick = ref_lvl_d & ~ref_lvl_q;
    // Shift register
    sr_d = sr_q;
    if (sclk_rise) begin
      sr_d = {sr_q[SR_LEN-2:0], sd_s};
    end
    // Serial word fields
    ser_cfg.t = sr_q[T_LSB +: 3];
    ser_cfg.n = sr_q[N_LSB +: 2];
    ser_cfg.m = sr_q[M_LSB +: 7];
    // Configuration latches
    cfg_d = cfg_q;
    if (sl_s || sl_fall) begin
      cfg_d = ser_cfg;
    end
    if (!pl_s || pl_rise) begin
      cfg_d.m = m_s;
      cfg_d.n = n_s;
    end
    // Slow-down stepping on reference edges
    slow_req_d = slow_req_q;
    step_d = step_q;
    if (ref_tick) begin
      slow_req_d = sdr_s;
      if (slow_req_q && step_q < SLOW_STEPS) begin
        step_d = step_q + 3'h1;
      end else if (!slow_req_q && step_q != 3'h0) begin
        step_d = step_q - 3'h1;
      end
    end
    case (cfg_q.n)
      2'h0: base = POST_DIV2;
      2'h1: base = POST_DIV4;
      2'h2: base = POST_DIV8;
      default: base = POST_DIV1;
    endcase
    ratio_d = base << step_q;
    // Output gate only moves while divider output is low
    gate_d = gate_q;
    if (!post_out) begin
      gate_d = oe_s & ctrl_en_q;
    end
    fout_d = post_out & gate_q;
    fout_n_d = ~(post_out & gate_q);
    case (cfg_q.t)
      3'h0: diag_d = 1'b0;
      3'h1: diag_d = ref_lvl_q;
      3'h2: diag_d = fb_out;
      3'h3: diag_d = post_out;
      3'h4: diag_d = sr_q[SR_LEN-1];
      3'h5: diag_d = slow_req_q;
      3'h6: diag_d = gate_q;
      default: diag_d = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase
  always_comb begin
    apb_wr = psel & penable & pready_q & pwrite;
    ctrl_en_d = ctrl_en_q;
    if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl_en_d = pwdata[0];
    end
    pready_d = psel & ~penable;
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        ADDR_CTRL: prdata_d = {31'h0, ctrl_en_q};
        ADDR_CFG: prdata_d = {20'h0, cfg_q};
        ADDR_STAT: prdata_d = {24'h0, gate_q, pl_s, sl_s, rsel_s,
                               slow_req_q, step_q};
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= '{m: CFG_M_RST, n: CFG_N_RST, t: CFG_T_RST};
      sr_q <= '0;
      pl_prev_q <= PIN_PLOAD_RST;
      sl_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      ref_lvl_q <= 1'b0;
      slow_req_q <= 1'b0;
      step_q <= 3'h0;
      gate_q <= 1'b0;
      ctrl_en_q <= CTRL_RST;
      ratio_q <= POST_DIV1;
      ref_clk_q <= 1'b0;
      fb_clk_q <= 1'b0;
      fout_q <= 1'b0;
      fout_n_q <= 1'b1;
      diag_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      sr_q <= sr_d;
      pl_prev_q <= pl_prev_d;
      sl_prev_q <= sl_prev_d;
      sclk_prev_q <= sclk_prev_d;
      ref_lvl_q <= ref_lvl_d;
      slow_req_q <= slow_req_d;
      step_q <= step_d;
      gate_q <= gate_d;
      ctrl_en_q <= ctrl_en_d;
      ratio_q <= ratio_d;
      ref_clk_q <= ref_clk_d;
      fb_clk_q <= fb_out;
      fout_q <= fout_d;
      fout_n_q <= fout_n_d;
      diag_q <= diag_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_par_transp;
    @(posedge clk) disable iff (reset) !pl_s |=> cfg_q.m == $past(m_s);
  endproperty
  a_par_transp: assert property (p_par_transp) else $error("par transparency");

  property p_par_capture;
    @(posedge clk) disable iff (reset)
      pl_rise ##1 (pl_s && !sl_s && !sl_fall)[*3] |-> cfg_q.n == $past(n_s, 3);
  endproperty
  a_par_capture: assert property (p_par_capture) else $error("par capture");

  property p_par_prio;
    @(posedge clk) disable iff (reset)
      (!pl_s && sl_s) |=> cfg_q.m == $past(m_s) && cfg_q.t == $past(sr_q[2:0]);
  endproperty
  a_par_prio: assert property (p_par_prio) else $error("parallel priority");

  property p_shift;
    @(posedge clk) disable iff (reset)
      sclk_rise |=> sr_q == {$past(sr_q[SR_LEN-2:0]), $past(sd_s)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift step");

  property p_ser_capture;
    @(posedge clk) disable iff (reset)
      (sl_fall && pl_s && !pl_rise) |=> cfg_q.m == $past(sr_q[11:5]);
  endproperty
  a_ser_capture: assert property (p_ser_capture) else $error("serial capture");

  property p_step_one;
    @(posedge clk) disable iff (reset)
      step_q <= SLOW_STEPS && (step_q - $past(step_q) == 3'h1 ||
      $past(step_q) - step_q == 3'h1 || step_q == $past(step_q));
  endproperty
  a_step_one: assert property (p_step_one) else $error("step jump");

  property p_step_ref;
    @(posedge clk) disable iff (reset) !ref_tick |=> $stable(step_q);
  endproperty
  a_step_ref: assert property (p_step_ref) else $error("step off ref");

  property p_gate_low;
    @(posedge clk) disable iff (reset) !gate_q |=> !fout_q && fout_n_q;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gated output");

  property p_ratio;
    @(posedge clk) disable iff (reset)
      ##1 ratio_q == 8'($past(base) << $past(step_q));
  endproperty
  a_ratio: assert property (p_ratio) else $error("post ratio");

  c_full_slow: cover property (@(posedge clk) disable iff (reset)
    step_q == SLOW_STEPS);
  c_ser_load: cover property (@(posedge clk) disable iff (reset)
    sl_fall && pl_s);
  c_par_load: cover property (@(posedge clk) disable iff (reset) pl_rise);
endmodule
`default_nettype wire

/* tb/pls_ctl_model.sv */
`default_nettype none
// Board controller driving the parallel and serial configuration pins
module pls_ctl_model (
  input wire logic clk,
  output var logic [6:0] par_fb_div_in,
  output var logic [6:0] par_fb_div_drive,
  output var logic [1:0] par_post_sel_in,
  output var logic [1:0] par_post_sel_drive,
  output var logic par_latch_n,
  output var logic ser_clock,
  output var logic ser_data,
  output var logic ser_latch
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    par_latch_n = 1'b0;
    {par_fb_div_in, par_fb_div_drive, par_post_sel_in, par_post_sel_drive} = '0;
    {ser_clock, ser_data, ser_latch} = '0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Parallel load, then pins move away; low_stay keeps latches open
  task automatic par_load(input logic [6:0] m, md, input logic [1:0] n, nd, input logic low_stay);
    par_latch_n <= 1'b0;
    par_fb_div_in <= m;
    par_fb_div_drive <= md;
    par_post_sel_in <= n;
    par_post_sel_drive <= nd;
    hold(4);
    par_latch_n <= ~low_stay;
    hold(4);
    par_fb_div_in <= ~m;
    par_post_sel_in <= ~n;
    hold(5);
  endtask
  // Twelve bits, first bit first; latch left high when stay is set
  task automatic ser_load(input logic [11:0] w, input logic stay);
    for (int i = 11; i >= 0; i--) begin
      ser_data <= w[i];
      hold(4);
      ser_clock <= 1'b1;
      hold(4);
      ser_clock <= 1'b0;
      hold(1);
    end
    ser_latch <= 1'b1;
    ser_data <= ~w[0];
    hold(4);
    if (!stay) begin
      ser_latch <= 1'b0;
    end
    hold(5);
  endtask
  task automatic ser_drop();
    ser_latch <= 1'b0;
    hold(5);
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb
  import pls_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, output_enable = 1'b1;
  logic slow_down_request = 1'b0, ref_source_select = 1'b1, vco_tick = 1'b1;
  logic xtal_ref_in = 1'b0, external_reference_in = 1'b0, msel = 1'b0, er;
  logic [11:0] paddr = '0, w;
  logic [31:0] pwdata = '0, rd, prdata_q;
  logic pready_q, pslverr_q, par_latch_n, ser_clock, ser_data, ser_latch;
  logic ref_clk_q, fb_clk_q, fout_q, fout_n_q, diag_q;
  logic [6:0] par_fb_div_in, par_fb_div_drive;
  logic [1:0] par_post_sel_in, par_post_sel_drive;
  wire logic ms = msel ? fb_clk_q : fout_q;
  int n_errors = 0, total_checks = 0, cyc = 0;
  pls_ctl_model model_u (.clk, .par_fb_div_in, .par_fb_div_drive, .par_post_sel_in,
    .par_post_sel_drive, .par_latch_n, .ser_clock, .ser_data, .ser_latch);
  pls_ctrl dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .par_fb_div_in, .par_fb_div_drive, .par_post_sel_in,
    .par_post_sel_drive, .par_latch_n, .ser_clock, .ser_data, .ser_latch, .output_enable,
    .slow_down_request, .ref_source_select, .xtal_ref_in, .external_reference_in,
    .vco_tick, .ref_clk_q, .fb_clk_q, .fout_q, .fout_n_q, .diag_q);
  ////////////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  always begin
    repeat (20) @(posedge clk);
    xtal_ref_in <= ~xtal_ref_in;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready_q !== 1'b1);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd, e);
  endtask
  // Period and high time of fout or feedback clock, in clk cycles
  task automatic meas(input logic s, input int per);
    int t, h;
    msel = s;
    h = 0;
    do @(posedge clk); while (ms !== 1'b0);
    do @(posedge clk); while (ms !== 1'b1);
    do begin h++; @(posedge clk); end while (ms === 1'b1);
    t = h;
    do begin t++; @(posedge clk); end while (ms === 1'b0);
    chk(t, per);
    chk(h, per / 2);
  endtask
  task automatic quiet(input logic [1:0] e, input logic r);
    repeat (8) @(posedge clk);
    repeat (45) begin
      @(posedge clk);
      if (r) chk(ref_clk_q, e[0]);
      else chk({fout_q, fout_n_q}, e);
    end
  endtask
  task automatic slow_walk(input logic up, input logic [2:0] last);
    logic [2:0] p;
    int c;
    p = up ? 3'h0 : 3'h4;
    c = 0;
    slow_down_request <= up;
    repeat (120) begin
      apb(1'b0, ADDR_STAT, '0);
      if (rd[2:0] !== p) begin
        chk(up ? rd[2:0] - p : p - rd[2:0], 32'h1);
        c++;
        p = rd[2:0];
      end
    end
    chk(c, 4);
    chk(rd[3:0], {up, last});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk(ADDR_CTRL, 32'h1);
    rdchk(ADDR_CFG, 32'hFF8);
    apb(1'b0, 12'h00C, '0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_CFG, '0);
    rdchk(ADDR_CFG, 32'hFF8);
    model_u.par_load(7'h23, 7'h7F, 2'h0, 2'h3, 1'b0);
    rdchk(ADDR_CFG, 32'h460);
    model_u.par_load(7'h00, 7'h0F, 2'h0, 2'h1, 1'b0);
    rdchk(ADDR_CFG, 32'hE10);
    model_u.par_load(7'h11, 7'h7F, 2'h1, 2'h3, 1'b1);
    rdchk(ADDR_CFG, 32'hDD0);
    model_u.ser_load(12'hFFD, 1'b0);
    rdchk(ADDR_CFG, 32'hDD5);
    model_u.par_load(7'h11, 7'h7F, 2'h1, 2'h3, 1'b0);
    rdchk(ADDR_CFG, 32'h22D);
    model_u.ser_load(12'h5A3, 1'b1);
    rdchk(ADDR_CFG, 32'h5A3);
    model_u.ser_drop();
    for (int n = 0; n < 4; n++) begin
      w = {7'h05, 2'(n), n[0] ? 3'h7 : 3'h0};
      model_u.ser_load(w, 1'b0);
      rdchk(ADDR_CFG, {20'h0, w});
      chk(diag_q, n[0]);
      meas(1'b0, n == 3 ? 2 : 4 << n);
    end
    meas(1'b1, 10);
    output_enable <= 1'b0;
    quiet(2'b01, 1'b0);
    output_enable <= 1'b1;
    apb(1'b1, ADDR_CTRL, '0);
    quiet(2'b01, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    meas(1'b0, 2);
    slow_walk(1'b1, 3'h4);
    meas(1'b0, 32);
    slow_walk(1'b0, 3'h0);
    meas(1'b0, 2);
    external_reference_in <= 1'b1;
    ref_source_select <= 1'b0;
    repeat (6) @(posedge clk);
    quiet(2'b01, 1'b1);
    external_reference_in <= 1'b0;
    repeat (6) @(posedge clk);
    quiet(2'b00, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
